// *** src/sfd_device.sv ***
// Purpose: Device end: takes the instruction byte off the link and classifies it.
// Assumes: Link clock well below the reference clock, so that three-stage sampling sees every edge.
// Notes: Address, mode and data phases are left to the memory core; this end only decodes.
//
// Behaviour
// - 03 normal read, 13 four-byte; 50 MHz.
// - 0B fast read, three or four bytes.
// - 0C fast read, always four-byte address.
// - 0D, 0E double-rate fast read; 80 MHz.
// - 3B, 3C two-line output reads; 104 MHz.
// - 6B, 6C four-line output reads; 104 MHz.
// - BB, BC two-line address-data reads; 104 MHz.
// - BD, BE double-rate two-line reads; 80 MHz.
// - EB, EC four-line address-data reads; 104 MHz.
// - ED, EE double-rate four-line reads; 80 MHz.
// - 02, 12 single-line page write; 133 MHz.
// - 32, 38, 34 four-line page write; 80 MHz.
// - D8, DC wipe one 256 kB sector.
// - 5A parameter read, 9F identity read.
// - 41 reads the learning pattern.
// - 43 nonvolatile, 4A volatile pattern write.
// - Old power-down code means bank access.
// - A3 reserved, performs no defined operation.
// - Nonvolatile write costs one array wear cycle.
// - Eight ones on line zero release continuous mode.
`timescale 1ns/100ps
module sfd_device
  import sfd_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  sfd_link_if.device               link,
  input  wire logic                cont_enter_i,
  output logic                     cmd_valid_o,
  output logic [7:0]               cmd_op_o,
  output sfd_class_t               cmd_class_o,
  output logic                     wide_addr_o,
  output logic [7:0]               max_mhz_o,
  output logic                     ignored_o,
  output logic                     nv_cycle_o,
  output logic [NV_CNT_W-1:0]      nv_pe_count_o,
  output logic                     bank_access_o,
  output logic                     cont_mode_o,
  output logic                     cont_release_o,
  output logic                     frame_active_o
);

  typedef enum logic [1:0] {DV_IDLE, DV_OPCODE, DV_BUSY, DV_IGNORE} sfd_dev_state_t;

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  // Only chip select, clock and line zero are watched; the other lines are don't-care here.
  sfd_sync #(
    .W       (3),
    .RST_VAL (3'h5)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({link.cs_n, link.sck, link.io[0]}),
    .level_o   (pin_level),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  wire cs_high   = pin_level[2];
  wire cs_fall   = pin_fall[2];
  wire sck_rise  = pin_rise[1];
  wire line_zero = pin_level[0];

  sfd_dev_state_t        state_ff;
  sfd_dev_state_t        nxt_state;
  logic [6:0]            shift_ff;
  logic [2:0]            bit_cnt_ff;
  logic [7:0]            last_read_ff;
  logic                  cmd_valid_ff;
  logic [7:0]            cmd_op_ff;
  sfd_class_t            cmd_class_ff;
  logic                  wide_ff;
  logic [7:0]            mhz_ff;
  logic                  ignored_ff;
  logic                  nv_cycle_ff;
  logic [NV_CNT_W-1:0]   nv_count_ff;
  logic                  bank_ff;
  logic                  cont_ff;
  logic                  release_ff;
  logic                  active_ff;

  // The byte is complete on the eighth rising clock edge of the frame.
  wire        in_opcode   = (state_ff == DV_OPCODE);
  wire        take_bit    = in_opcode & sck_rise & ~cs_high;
  wire        byte_done   = take_bit & (bit_cnt_ff == LAST_BIT);
  wire [7:0]  full_byte   = {shift_ff, line_zero};
  wire        is_release  = byte_done & cont_ff & (full_byte == RELEASE_BYTE);
  // In continuous mode the frame carries no instruction; the previous read is implied.
  wire [7:0]  dec_op      = cont_ff ? last_read_ff : full_byte;
  sfd_class_t dec_class;
  assign dec_class = sfd_classify(dec_op);
  wire        dec_known   = (dec_class != CLS_NONE) & (dec_class != CLS_RESERVED);
  wire        accept      = byte_done & ~is_release & dec_known;
  wire        reject      = byte_done & ~is_release & ~dec_known;
  wire        is_read     = dec_class inside {CLS_READ, CLS_FAST_READ, CLS_DDR_READ, CLS_TWO_OUT,
                                              CLS_FOUR_OUT, CLS_TWO_IO, CLS_DDR_TWO_IO,
                                              CLS_FOUR_IO, CLS_DDR_FOUR_IO};
  wire        is_nv_write = accept & (dec_class == CLS_PAT_NV_WRITE);
  wire        cur_io_read = cmd_class_ff inside {CLS_TWO_IO, CLS_DDR_TWO_IO, CLS_FOUR_IO, CLS_DDR_FOUR_IO};
  wire        enter_cont  = cont_enter_i & (state_ff == DV_BUSY) & cur_io_read;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DV_IDLE: begin
        if (cs_fall) begin
          nxt_state = DV_OPCODE;
        end
      end
      DV_OPCODE: begin
        if (cs_high) begin
          nxt_state = DV_IDLE;
        end else if (accept) begin
          nxt_state = DV_BUSY;
        end else if (byte_done) begin
          nxt_state = DV_IGNORE;
        end
      end
      DV_BUSY, DV_IGNORE: begin
        if (cs_high) begin
          nxt_state = DV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff   <= DV_IDLE;
      shift_ff   <= '0;
      bit_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (cs_fall) begin
        bit_cnt_ff <= '0;
      end else if (take_bit) begin
        shift_ff   <= full_byte[6:0];
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
    end
  end

  // Decode results stand until the next accepted instruction; rejected codes leave them alone.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_op_ff    <= '0;
      cmd_class_ff <= CLS_NONE;
      wide_ff      <= 1'b0;
      mhz_ff       <= MHZ_NONE;
      bank_ff      <= 1'b0;
      last_read_ff <= OP_READ;
    end else if (accept) begin
      cmd_op_ff    <= dec_op;
      cmd_class_ff <= dec_class;
      wide_ff      <= sfd_wide_only(dec_op);
      mhz_ff       <= sfd_max_mhz(dec_op);
      bank_ff      <= (dec_class == CLS_BANK_ACCESS);
      if (is_read) begin
        last_read_ff <= dec_op;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_ff <= 1'b0;
      ignored_ff   <= 1'b0;
      nv_cycle_ff  <= 1'b0;
      release_ff   <= 1'b0;
      active_ff    <= 1'b0;
    end else begin
      cmd_valid_ff <= accept;
      ignored_ff   <= reject;
      nv_cycle_ff  <= is_nv_write;
      release_ff   <= is_release;
      active_ff    <= ~cs_high;
    end
  end

  // The wear count covers the whole nonvolatile register array; the volatile pattern write costs none.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nv_count_ff <= '0;
    end else if (is_nv_write) begin
      nv_count_ff <= nv_count_ff + {{(NV_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Entering continuous mode wins over a release in the same cycle, which cannot occur together.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cont_ff <= 1'b0;
    end else if (enter_cont) begin
      cont_ff <= 1'b1;
    end else if (is_release) begin
      cont_ff <= 1'b0;
    end
  end

  assign cmd_valid_o    = cmd_valid_ff;
  assign cmd_op_o       = cmd_op_ff;
  assign cmd_class_o    = cmd_class_ff;
  assign wide_addr_o    = wide_ff;
  assign max_mhz_o      = mhz_ff;
  assign ignored_o      = ignored_ff;
  assign nv_cycle_o     = nv_cycle_ff;
  assign nv_pe_count_o  = nv_count_ff;
  assign bank_access_o  = bank_ff;
  assign cont_mode_o    = cont_ff;
  assign cont_release_o = release_ff;
  assign frame_active_o = active_ff;

endmodule : sfd_device

// *** inc/sfd_pkg.sv ***
// Purpose: Shared constants, command classes and decode functions of the serial flash command decoder.
// Assumes: Reference clock of 100 MHz; instruction codes are eight bits wide.
// Notes: The decode functions are shared by the device end and the host end.
package sfd_pkg;

  localparam int         REF_MHZ        = 100;
  localparam int         SCK_HALF_CYC   = 4;
  localparam int         SCK_MHZ        = REF_MHZ / (2 * SCK_HALF_CYC);
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [7:0] RELEASE_BYTE   = 8'hff;
  localparam int         NV_CNT_W       = 24;

  // Highest serial clock rate per instruction, in MHz.
  localparam logic [7:0] MHZ_NORMAL     = 8'h32;
  localparam logic [7:0] MHZ_FAST       = 8'h85;
  localparam logic [7:0] MHZ_MULTI      = 8'h68;
  localparam logic [7:0] MHZ_DOUBLE     = 8'h50;
  localparam logic [7:0] MHZ_NONE       = 8'h00;

  localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;
  localparam logic [7:0] OP_FAST_READ_W  = 8'h0c;
  localparam logic [7:0] OP_DDR_FR       = 8'h0d;
  localparam logic [7:0] OP_DDR_FR_W     = 8'h0e;
  localparam logic [7:0] OP_PAGE_WRITE_W = 8'h12;
  localparam logic [7:0] OP_READ_W       = 8'h13;
  localparam logic [7:0] OP_QPW_A        = 8'h32;
  localparam logic [7:0] OP_QPW_W        = 8'h34;
  localparam logic [7:0] OP_QPW_B        = 8'h38;
  localparam logic [7:0] OP_TWO_OUT      = 8'h3b;
  localparam logic [7:0] OP_TWO_OUT_W    = 8'h3c;
  localparam logic [7:0] OP_PAT_READ     = 8'h41;
  localparam logic [7:0] OP_PAT_NV_WR    = 8'h43;
  localparam logic [7:0] OP_PAT_VOL_WR   = 8'h4a;
  localparam logic [7:0] OP_PARAM_READ   = 8'h5a;
  localparam logic [7:0] OP_FOUR_OUT     = 8'h6b;
  localparam logic [7:0] OP_FOUR_OUT_W   = 8'h6c;
  localparam logic [7:0] OP_IDENT_READ   = 8'h9f;
  localparam logic [7:0] OP_PERF_MODE    = 8'ha3;
  localparam logic [7:0] OP_BANK_ACCESS  = 8'hb9;
  localparam logic [7:0] OP_TWO_IO       = 8'hbb;
  localparam logic [7:0] OP_TWO_IO_W     = 8'hbc;
  localparam logic [7:0] OP_DDR_TWO_IO   = 8'hbd;
  localparam logic [7:0] OP_DDR_TWO_IO_W = 8'hbe;
  localparam logic [7:0] OP_SECTOR_WIPE  = 8'hd8;
  localparam logic [7:0] OP_SECTOR_WIPE_W = 8'hdc;
  localparam logic [7:0] OP_FOUR_IO      = 8'heb;
  localparam logic [7:0] OP_FOUR_IO_W    = 8'hec;
  localparam logic [7:0] OP_DDR_FOUR_IO  = 8'hed;
  localparam logic [7:0] OP_DDR_FOUR_IO_W = 8'hee;

  typedef enum logic [4:0] {
    CLS_NONE, CLS_READ, CLS_FAST_READ, CLS_DDR_READ, CLS_TWO_OUT, CLS_FOUR_OUT,
    CLS_TWO_IO, CLS_DDR_TWO_IO, CLS_FOUR_IO, CLS_DDR_FOUR_IO, CLS_PAGE_WRITE,
    CLS_FOUR_PAGE_WRITE, CLS_SECTOR_WIPE, CLS_PARAM_READ, CLS_IDENT_READ,
    CLS_PAT_READ, CLS_PAT_NV_WRITE, CLS_PAT_VOL_WRITE, CLS_BANK_ACCESS, CLS_RESERVED
  } sfd_class_t;

  function automatic sfd_class_t sfd_classify(input logic [7:0] op);
    case (op)
      OP_READ, OP_READ_W:                  return CLS_READ;
      OP_FAST_READ, OP_FAST_READ_W:        return CLS_FAST_READ;
      OP_DDR_FR, OP_DDR_FR_W:              return CLS_DDR_READ;
      OP_TWO_OUT, OP_TWO_OUT_W:            return CLS_TWO_OUT;
      OP_FOUR_OUT, OP_FOUR_OUT_W:          return CLS_FOUR_OUT;
      OP_TWO_IO, OP_TWO_IO_W:              return CLS_TWO_IO;
      OP_DDR_TWO_IO, OP_DDR_TWO_IO_W:      return CLS_DDR_TWO_IO;
      OP_FOUR_IO, OP_FOUR_IO_W:            return CLS_FOUR_IO;
      OP_DDR_FOUR_IO, OP_DDR_FOUR_IO_W:    return CLS_DDR_FOUR_IO;
      OP_PAGE_WRITE, OP_PAGE_WRITE_W:      return CLS_PAGE_WRITE;
      OP_QPW_A, OP_QPW_B, OP_QPW_W:        return CLS_FOUR_PAGE_WRITE;
      OP_SECTOR_WIPE, OP_SECTOR_WIPE_W:    return CLS_SECTOR_WIPE;
      OP_PARAM_READ:                       return CLS_PARAM_READ;
      OP_IDENT_READ:                       return CLS_IDENT_READ;
      OP_PAT_READ:                         return CLS_PAT_READ;
      OP_PAT_NV_WR:                        return CLS_PAT_NV_WRITE;
      OP_PAT_VOL_WR:                       return CLS_PAT_VOL_WRITE;
      OP_BANK_ACCESS:                      return CLS_BANK_ACCESS;
      OP_PERF_MODE:                        return CLS_RESERVED;
      default:                             return CLS_NONE;
    endcase
  endfunction : sfd_classify

  // True for the codes whose address is four bytes whatever the address-length setting.
  function automatic logic sfd_wide_only(input logic [7:0] op);
    return op inside {OP_READ_W, OP_FAST_READ_W, OP_DDR_FR_W, OP_TWO_OUT_W, OP_FOUR_OUT_W,
                      OP_TWO_IO_W, OP_DDR_TWO_IO_W, OP_FOUR_IO_W, OP_DDR_FOUR_IO_W,
                      OP_PAGE_WRITE_W, OP_QPW_W, OP_SECTOR_WIPE_W};
  endfunction : sfd_wide_only

  function automatic logic [7:0] sfd_max_mhz(input logic [7:0] op);
    case (sfd_classify(op))
      CLS_NONE:                                          return MHZ_NONE;
      CLS_READ:                                          return MHZ_NORMAL;
      CLS_TWO_OUT, CLS_FOUR_OUT, CLS_TWO_IO, CLS_FOUR_IO: return MHZ_MULTI;
      CLS_DDR_READ, CLS_DDR_TWO_IO, CLS_DDR_FOUR_IO,
      CLS_FOUR_PAGE_WRITE:                               return MHZ_DOUBLE;
      default:                                           return MHZ_FAST;
    endcase
  endfunction : sfd_max_mhz

endpackage : sfd_pkg

// *** inc/sfd_link_if.sv ***
// Purpose: Serial link between the host end and the device end.
// Assumes: Unused data lines float high through a pull-up.
// Notes: The resolved level of each data line is worked out here from the host enables.
`timescale 1ns/100ps
interface sfd_link_if;
  logic       cs_n;
  logic       sck;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] io;

  assign io = (host_io_o & host_io_oe) | ~host_io_oe;

  modport host   (output cs_n, output sck, output host_io_o, output host_io_oe, input io);
  modport device (input cs_n, input sck, input io);
endinterface : sfd_link_if

// *** src/sfd_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter and edge pulses.
// Assumes: Inputs are asynchronous to the reference clock.
// Notes: A change is taken only when the second and third stages agree.
`timescale 1ns/100ps
module sfd_sync #(
  parameter int         W       = 3,
  parameter logic [2:0] RST_VAL = 3'h0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] rise_ff;
  logic [W-1:0] fall_ff;
  wire  [W-1:0] agree    = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_lvl  = (agree & s2_ff) | (~agree & lvl_ff);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_ff   <= RST_VAL[W-1:0];
      s2_ff   <= RST_VAL[W-1:0];
      s3_ff   <= RST_VAL[W-1:0];
      lvl_ff  <= RST_VAL[W-1:0];
      rise_ff <= '0;
      fall_ff <= '0;
    end else begin
      s1_ff   <= async_i;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      lvl_ff  <= nxt_lvl;
      rise_ff <= nxt_lvl & ~lvl_ff;
      fall_ff <= ~nxt_lvl & lvl_ff;
    end
  end

  assign level_o = lvl_ff;
  assign rise_o  = rise_ff;
  assign fall_o  = fall_ff;
endmodule : sfd_sync

// *** src/sfd_host.sv ***
// Purpose: Host end: sends one instruction byte, or the release pattern, in a chip-select frame.
// Assumes: The serial clock is made here by dividing the reference clock.
// Notes: One fixed slow rate serves every instruction, so no per-code rate switching is needed.
`timescale 1ns/100ps
module sfd_host
  import sfd_pkg::*;
(
  input  wire logic  ref_clk_i,
  input  wire logic  rst_n_i,
  sfd_link_if.host   link,
  input  wire logic  start_i,
  input  wire logic  [7:0] op_i,
  input  wire logic  release_i,
  output logic       busy_o,
  output logic       done_o,
  output logic       refused_o
);

  typedef enum logic [2:0] {HS_IDLE, HS_LEAD, HS_HIGH, HS_LOW, HS_TRAIL, HS_GAP} sfd_host_state_t;

  localparam logic [2:0] HALF_LAST = 3'(SCK_HALF_CYC - 1);

  sfd_host_state_t state_ff;
  sfd_host_state_t nxt_state;
  logic [2:0]      tmr_ff;
  logic [2:0]      bit_ff;
  logic [7:0]      data_ff;
  logic            cs_n_ff;
  logic            sck_ff;
  logic            io0_ff;
  logic            oe_ff;
  logic            done_ff;
  logic            refused_ff;
  logic            busy_ff;

  // The divided clock must not exceed the limit of the code sent; a zero limit means an unknown code.
  wire [7:0] send_op   = release_i ? RELEASE_BYTE : op_i;
  wire [7:0] op_limit  = sfd_max_mhz(send_op);
  wire       too_fast  = (op_limit != MHZ_NONE) & (8'(SCK_MHZ) > op_limit);
  wire       idle      = (state_ff == HS_IDLE);
  wire       req       = idle & (start_i | release_i);
  wire       launch    = req & ~too_fast;
  wire       half_end  = (tmr_ff == HALF_LAST);
  wire       last_bit  = (bit_ff == LAST_BIT);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      HS_IDLE:  if (launch) nxt_state = HS_LEAD;
      HS_LEAD:  if (half_end) nxt_state = HS_HIGH;
      HS_HIGH:  if (half_end) nxt_state = last_bit ? HS_TRAIL : HS_LOW;
      HS_LOW:   if (half_end) nxt_state = HS_HIGH;
      HS_TRAIL: if (half_end) nxt_state = HS_GAP;
      HS_GAP:   if (half_end) nxt_state = HS_IDLE;
    endcase
  end

  wire step   = ~idle & half_end;
  wire to_low = step & (state_ff == HS_HIGH) & ~last_bit;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= HS_IDLE;
      tmr_ff   <= '0;
      bit_ff   <= '0;
      data_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= (idle | half_end) ? 3'h0 : tmr_ff + 3'h1;
      if (launch) begin
        data_ff <= send_op;
        bit_ff  <= '0;
      end else if (to_low) begin
        data_ff <= {data_ff[6:0], 1'b0};
        bit_ff  <= bit_ff + 3'h1;
      end
    end
  end

  // Data changes only while the clock is low, so the device always samples a settled bit.
  wire nxt_cs_n = ~(nxt_state inside {HS_LEAD, HS_HIGH, HS_LOW, HS_TRAIL});
  wire nxt_sck  = (nxt_state == HS_HIGH);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_n_ff    <= 1'b1;
      sck_ff     <= 1'b0;
      io0_ff     <= 1'b1;
      oe_ff      <= 1'b0;
      done_ff    <= 1'b0;
      refused_ff <= 1'b0;
      busy_ff    <= 1'b0;
    end else begin
      cs_n_ff    <= nxt_cs_n;
      sck_ff     <= nxt_sck;
      io0_ff     <= launch ? send_op[7] : (to_low ? data_ff[6] : io0_ff);
      oe_ff      <= ~nxt_cs_n;
      done_ff    <= step & (state_ff == HS_GAP);
      refused_ff <= req & too_fast;
      busy_ff    <= (nxt_state != HS_IDLE);
    end
  end

  assign link.cs_n       = cs_n_ff;
  assign link.sck        = sck_ff;
  assign link.host_io_o  = {3'h7, io0_ff};
  assign link.host_io_oe = {3'h0, oe_ff};
  assign busy_o          = busy_ff;
  assign done_o          = done_ff;
  assign refused_o       = refused_ff;

endmodule : sfd_host

// *** test/sfd_link_properties.sv ***
// Purpose: Timing and framing checks on the link between the host end and the device end.
// Assumes: Serial clock half period of four reference cycles.
// Notes: Sees only link signals, so any pair of ends can be checked.
`timescale 1ns/100ps
module sfd_link_properties (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] host_io_o,
  input  wire logic [3:0] host_io_oe,
  input  wire logic [3:0] io
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sck_idle_low:
    assert property (cs_n |-> !sck) else $error("serial clock moved outside a frame");
  a_drive_in_frame:
    assert property (host_io_oe[0] |-> !cs_n) else $error("line zero driven outside a frame");
  a_upper_lines_off:
    assert property (host_io_oe[3:1] == 3'h0) else $error("upper data lines driven");
  a_line_follows:
    assert property (host_io_oe[0] |-> io[0] == host_io_o[0]) else $error("line zero level wrong");
  a_bit_stable:
    assert property (sck |-> $stable(io[0])) else $error("data changed while clock high");
  a_sck_high_time:
    assert property ($rose(sck) |-> sck [*4] ##1 !sck) else $error("clock high time wrong");
  a_select_lead:
    assert property ($fell(cs_n) |-> !sck [*4] ##1 sck) else $error("first clock edge misplaced");
  a_frame_length:
    assert property ($fell(cs_n) |-> ##68 $rose(cs_n)) else $error("frame length wrong");
  a_select_gap:
    assert property ($rose(cs_n) |-> cs_n [*4]) else $error("deselect gap too short");
  c_frame: cover property ($fell(cs_n));
  c_zero_bit: cover property (sck && !io[0]);
  c_one_bit: cover property (sck && io[0]);
endmodule : sfd_link_properties

// *** test/spi_flash_command_decoder_tb.sv ***
// Purpose: Self-checking bench joining the host end to the device end.
// Assumes: Host makes the serial clock at its single fixed rate.
// Notes: Expected decodes come from the code table below, never from the design.
`timescale 1ns/100ps
module spi_flash_command_decoder_tb;
  import sfd_pkg::*;
  logic                clk, rst_n, start, rel, cont_en, done, busy, refused;
  logic                valid, ign, wide, bank, cmode, crel, cm, nvc, fact;
  logic [27:0]         exp_note;
  logic [7:0]          op, cop, mhz;
  logic [NV_CNT_W-1:0] nv_cnt;
  sfd_class_t          cls;
  int                  num_errors = 0, checks = 0, nv_exp = 0;
  logic [27:0]         notes[$];
  logic [27:0]         last = 28'h0;
  // Entry: code, class, fixed four-byte flag, limit in MHz.
  logic [27:0] tbl [31] = '{
    28'h0301032, 28'h1301132, 28'h0b02085, 28'h0c02185, 28'h0d03050, 28'h0e03150,
    28'h3b04068, 28'h3c04168, 28'h6b05068, 28'h6c05168, 28'hbb06068, 28'hbc06168,
    28'hbd07050, 28'hbe07150, 28'heb08068, 28'hec08168, 28'hed09050, 28'hee09150,
    28'h020a085, 28'h120a185, 28'h320b050, 28'h380b050, 28'h340b150,
    28'hd80c085, 28'hdc0c185, 28'h5a0d085, 28'h9f0e085, 28'h410f085,
    28'h4310085, 28'h4a11085, 28'hb912085};

  sfd_link_if link ();
  sfd_host sfd_host_i (.ref_clk_i(clk), .rst_n_i(rst_n), .link(link.host), .start_i(start), .op_i(op),
    .release_i(rel), .busy_o(busy), .done_o(done), .refused_o(refused));
  sfd_device sfd_device_i (.ref_clk_i(clk), .rst_n_i(rst_n), .link(link.device), .cont_enter_i(cont_en),
    .cmd_valid_o(valid), .cmd_op_o(cop), .cmd_class_o(cls), .wide_addr_o(wide), .max_mhz_o(mhz),
    .ignored_o(ign), .nv_cycle_o(nvc), .nv_pe_count_o(nv_cnt), .bank_access_o(bank), .cont_mode_o(cmode),
    .cont_release_o(crel), .frame_active_o(fact));
  sfd_link_properties sfd_link_properties_i (.ref_clk_i(clk), .rst_n_i(rst_n), .cs_n(link.cs_n),
    .sck(link.sck), .host_io_o(link.host_io_o), .host_io_oe(link.host_io_oe), .io(link.io));

  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Notes the expected decode, then sends one frame; held outputs stay put on ignored codes.
  task automatic send(input logic [7:0] code, input logic r);
    logic [1:0] k;
    k = r ? 2'h2 : (cm ? 2'h0 : 2'h1);
    if (!r && !cm) foreach (tbl[i]) if (tbl[i][27:20] == code) begin
      k = 2'h0;
      last = {2'h0, code == 8'hb9, code, tbl[i][19:12], tbl[i][8], tbl[i][7:0]};
      nv_exp += (code == 8'h43);
    end
    notes.push_back({k, last[25:0]});
    if (r) cm = 1'b0;
    @(posedge clk);
    start <= !r;
    rel   <= r;
    op    <= code;
    @(posedge clk);
    start <= 1'b0;
    rel   <= 1'b0;
    @(negedge clk);
    chk({28'h0, busy, refused}, 30'h2);
    repeat (100) begin
      @(negedge clk);
      if (done) break;
    end
    // A frame that never ends is a failure of its own, not only a missing decode.
    if (done !== 1'b1) num_errors++;
  endtask : send

  always @(negedge clk) if (valid | ign | crel) begin
    exp_note = notes.size() > 0 ? notes.pop_front() : 28'h0;
    chk({2'h0, crel, ign, bank, cop, 3'h0, cls, wide, mhz}, {2'h0, exp_note});
    chk({28'h0, fact, nvc}, {28'h0, 1'b1, exp_note[27:26] == 2'h0 && exp_note[24:17] == OP_PAT_NV_WR});
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h50cf));
    {start, rel, cont_en, op, cm} = '0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (tbl[i]) send(tbl[i][27:20], 1'b0);
    send(OP_PERF_MODE, 1'b0);
    repeat (12) send(8'($urandom), 1'b0);
    @(posedge clk);
    cont_en <= 1'b1;
    send(OP_FOUR_IO, 1'b0);
    chk({29'h0, cmode}, 30'h1);
    @(posedge clk);
    cont_en <= 1'b0;
    cm = 1'b1;
    send(OP_READ, 1'b0);
    send(RELEASE_BYTE, 1'b1);
    chk({29'h0, cmode}, 30'h0);
    chk(30'(nv_cnt), 30'(nv_exp));
    chk(30'(notes.size()), 30'h0);
    report_and_stop();
  end
endmodule : spi_flash_command_decoder_tb
